// >>> temp_monitor_pkg.sv
// Register map, reset values, field positions and timing constants of the temperature monitor
package temp_monitor_pkg;
    // Read addresses
    localparam logic [7:0] RD_LOCAL_VALUE = 8'h00;
    localparam logic [7:0] RD_REMOTE_VALUE = 8'h01;
    localparam logic [7:0] RD_STATUS = 8'h02;
    localparam logic [7:0] RD_CONFIG = 8'h03;
    localparam logic [7:0] RD_RATE = 8'h04;
    localparam logic [7:0] RD_LOCAL_HIGH = 8'h05;
    localparam logic [7:0] RD_LOCAL_LOW = 8'h06;
    localparam logic [7:0] RD_REMOTE_HIGH = 8'h07;
    localparam logic [7:0] RD_REMOTE_LOW = 8'h08;
    localparam logic [7:0] RD_MAKER_ID = 8'hfe;
    localparam logic [7:0] RD_REVISION = 8'hff;
    // Write addresses
    localparam logic [7:0] WR_CONFIG = 8'h09;
    localparam logic [7:0] WR_RATE = 8'h0a;
    localparam logic [7:0] WR_LOCAL_HIGH = 8'h0b;
    localparam logic [7:0] WR_LOCAL_LOW = 8'h0c;
    localparam logic [7:0] WR_REMOTE_HIGH = 8'h0d;
    localparam logic [7:0] WR_REMOTE_LOW = 8'h0e;
    localparam logic [7:0] WR_ONE_SHOT = 8'h0f;
    // Reset values
    localparam logic [7:0] VALUE_RESET = 8'h80;
    localparam logic [7:0] HIGH_LIMIT_RESET = 8'h7f;
    localparam logic [7:0] LOW_LIMIT_RESET = 8'hc9;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] RATE_RESET = 8'h02;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [7:0] INVALID_READ = 8'h00;
    // Status bit positions
    localparam int STATUS_BUSY_BIT = 7;
    localparam int STATUS_LOCAL_OVER_BIT = 6;
    localparam int STATUS_LOCAL_UNDER_BIT = 5;
    localparam int STATUS_REMOTE_OVER_BIT = 4;
    localparam int STATUS_REMOTE_UNDER_BIT = 3;
    localparam int STATUS_OPEN_BIT = 2;
    // Configuration bit positions
    localparam int CONFIG_SUPPRESS_BIT = 7;
    localparam int CONFIG_STANDBY_BIT = 6;
    localparam int RATE_CODE_BITS = 3;
    localparam logic [2:0] RATE_CODE_MAX = 3'h7;
    // Timing: fastest conversion period, multiplied by 1 to 128 for slower codes
    localparam int CLOCK_KHZ = 200000;
    localparam int CONV_PERIOD_FAST_MS = 125;
    localparam int CONV_BASE_CYCLES = CONV_PERIOD_FAST_MS * CLOCK_KHZ;
endpackage : temp_monitor_pkg

// >>> temp_monitor_register_bank.sv
// Register bank, alarm flags, alert latch and conversion scheduling of the temperature monitor
//
// Function
// R1 - Value registers change only with converter results; bus writes cannot reach them.
// R2 - Status bit 7 is one while a conversion runs, else zero.
// R3 - Status bits 6 and 5 flag local over-high and under-low limit.
// R4 - Status bits 4 and 3 flag remote over-high and under-low limit.
// R5 - Status bit 2 flags open remote sensor; bits 1 and 0 reserved.
// R6 - Any flag set sets the alert latch and pulls alert low unless masked.
// R7 - Status read clears only flags whose cause has gone away.
// R8 - A set flag stays set until a status read or reset.
// R9 - Status read leaves alert latch; alert-response read clears it when all clear.
// R10 - Limits have separate read addresses 05-08 and write addresses 0B-0E.
// R11 - Reset loads values 0x80, high limits 0x7F, low limits 0xC9.
// R12 - Writing address 0F starts one conversion; its data byte is dropped.
// R13 - Configuration bit 6 high means standby; low means continuous conversion.
// R14 - Low standby pin forces standby regardless of configuration bit 6.
// R15 - In standby the value registers keep their last values.
// R16 - Configuration bit 7 masks the alert output; bits 5 to 0 reserved.
// R17 - Rate code low three bits divide conversions from 1 to 128.
// R18 - Host writes zero to upper rate bits and avoids codes above seven.
// R19 - Writes use write addresses, reads read addresses; wrong side is invalid.
// R20 - High flag trips on strictly greater, low flag on strictly less.
// R21 - A one-shot during standby returns to standby after it completes.
// R22 - First byte of each write loads the pointer selecting later accesses.
// R23 - Reserved status and configuration bits read as zero.
// R24 - Busy bit follows live conversion state and is not cleared by reads.
`timescale 1ns/1ps
module temp_monitor_register_bank #(
    parameter logic [31:0] BASE_PERIOD_CYCLES = temp_monitor_pkg::CONV_BASE_CYCLES[31:0],
    parameter logic [7:0] MAKER_ID_VALUE = 8'h5a,  // Arbitrary value
    parameter logic [7:0] REVISION_VALUE = 8'h01   // Arbitrary value
) (
    input wire logic clock,               // 200 MHz clock
    input wire logic rst,                 // Synchronous reset, active high
    input wire logic wr_valid,            // One-cycle strobe per received write byte
    input wire logic wr_first,            // Qualifies wr_valid: first byte of a write
    input wire logic [7:0] wr_data,       // Received write byte
    input wire logic rd_req,              // One-cycle strobe: host read of a byte
    input wire logic alert_resp_read,     // One-cycle strobe: alert-response address read
    input wire logic standby_pin_n,       // Standby pin, active low, asynchronous
    input wire logic conv_done,           // One-cycle strobe: converter results valid
    input wire logic [7:0] local_result,  // Local measurement from converter
    input wire logic [7:0] remote_result, // Remote measurement from converter
    input wire logic sensor_open,         // Remote sensor open-circuit level
    output logic [7:0] rd_data,           // Byte at pointer, registered
    output logic conv_start,              // One-cycle strobe to the converter
    output logic busy,                    // Conversion in progress
    output logic alert_n,                 // Alert output, active low
    output logic alert_oe                 // Open-drain enable: high while pulling low
);

    typedef enum logic [1:0] {
        IDLE = 2'b01,
        CONVERT = 2'b10
    } conv_state_t;

    function automatic logic at_addr(input logic [7:0] ptr, input logic [7:0] addr);
        at_addr = (ptr == addr);
    endfunction : at_addr

    conv_state_t state_reg, state_next;
    logic [7:0] pointer_reg;
    logic [7:0] local_value_reg, remote_value_reg;
    logic [7:0] local_high_reg, local_low_reg, remote_high_reg, remote_low_reg;
    logic alert_suppress_reg, standby_cfg_reg;
    logic [7:0] rate_reg;
    logic local_over_flag_reg, local_under_flag_reg;
    logic remote_over_flag_reg, remote_under_flag_reg, open_flag_reg;
    logic alert_latch_reg, alert_latch_next;
    logic oneshot_pending_reg;
    logic [31:0] period_count_reg;
    logic standby_meta_reg, standby_sync_reg;
    logic [7:0] rd_data_reg;
    logic conv_start_reg, busy_reg, alert_n_reg, alert_oe_reg;

    // Byte-level decode
    wire wr_pointer = wr_valid && wr_first;
    wire wr_reg = wr_valid && !wr_first;
    wire wr_config = wr_reg && at_addr(pointer_reg, temp_monitor_pkg::WR_CONFIG);
    wire wr_rate = wr_reg && at_addr(pointer_reg, temp_monitor_pkg::WR_RATE);
    wire wr_local_high = wr_reg && at_addr(pointer_reg, temp_monitor_pkg::WR_LOCAL_HIGH);
    wire wr_local_low = wr_reg && at_addr(pointer_reg, temp_monitor_pkg::WR_LOCAL_LOW);
    wire wr_remote_high = wr_reg && at_addr(pointer_reg, temp_monitor_pkg::WR_REMOTE_HIGH);
    wire wr_remote_low = wr_reg && at_addr(pointer_reg, temp_monitor_pkg::WR_REMOTE_LOW);
    wire wr_oneshot = wr_reg && at_addr(pointer_reg, temp_monitor_pkg::WR_ONE_SHOT);
    wire status_read = rd_req && at_addr(pointer_reg, temp_monitor_pkg::RD_STATUS);

    // Standby from either source
    wire standby = standby_cfg_reg || !standby_sync_reg; // R13 R14

    // Signed limit comparisons
    wire local_over_cond = $signed(local_value_reg) > $signed(local_high_reg); // R3 R20
    wire local_under_cond = $signed(local_value_reg) < $signed(local_low_reg); // R3 R20
    wire remote_over_cond = $signed(remote_value_reg) > $signed(remote_high_reg); // R4 R20
    wire remote_under_cond = $signed(remote_value_reg) < $signed(remote_low_reg); // R4 R20
    wire any_cond = local_over_cond || local_under_cond || remote_over_cond
        || remote_under_cond || sensor_open;
    wire any_flag = local_over_flag_reg || local_under_flag_reg || remote_over_flag_reg
        || remote_under_flag_reg || open_flag_reg;

    // Flags: cause sets, status read clears only a vanished cause; set wins
    wire local_over_next = local_over_cond || (local_over_flag_reg && !status_read); // R7 R8
    wire local_under_next = local_under_cond || (local_under_flag_reg && !status_read); // R7 R8
    wire remote_over_next = remote_over_cond || (remote_over_flag_reg && !status_read); // R7 R8
    wire remote_under_next = remote_under_cond || (remote_under_flag_reg && !status_read); // R7
    wire open_next = sensor_open || (open_flag_reg && !status_read); // R5 R7 R8

    // Alert latch: set wins over the alert-response clear
    wire alert_set = any_flag && !alert_suppress_reg; // R6 R16
    wire alert_clear = alert_resp_read && !any_flag && !any_cond; // R9
    assign alert_latch_next = alert_set || (alert_latch_reg && !alert_clear); // R6 R9

    // Conversion period: fastest period shifted up by (7 - code)
    wire [2:0] rate_code = rate_reg[temp_monitor_pkg::RATE_CODE_BITS-1:0]; // R17 R18
    wire [2:0] rate_shift = temp_monitor_pkg::RATE_CODE_MAX - rate_code;
    wire [31:0] period_cycles = BASE_PERIOD_CYCLES << rate_shift; // R17
    wire period_hit = (period_count_reg >= period_cycles - 32'h1);
    wire start_w = (state_reg == IDLE) && (oneshot_pending_reg || (!standby && period_hit));
    wire result_take = conv_done && (state_reg == CONVERT);

    // Read multiplexer
    wire [7:0] status_byte = {busy_reg, local_over_flag_reg, local_under_flag_reg,
        remote_over_flag_reg, remote_under_flag_reg, open_flag_reg, 2'h0}; // R2 R23 R24
    wire [7:0] config_byte = {alert_suppress_reg, standby_cfg_reg, 6'h0}; // R23
    logic [7:0] read_mux;

    always_comb begin
        case (pointer_reg) // R19 R22
            temp_monitor_pkg::RD_LOCAL_VALUE: read_mux = local_value_reg;
            temp_monitor_pkg::RD_REMOTE_VALUE: read_mux = remote_value_reg;
            temp_monitor_pkg::RD_STATUS: read_mux = status_byte;
            temp_monitor_pkg::RD_CONFIG: read_mux = config_byte;
            temp_monitor_pkg::RD_RATE: read_mux = rate_reg;
            temp_monitor_pkg::RD_LOCAL_HIGH: read_mux = local_high_reg; // R10
            temp_monitor_pkg::RD_LOCAL_LOW: read_mux = local_low_reg; // R10
            temp_monitor_pkg::RD_REMOTE_HIGH: read_mux = remote_high_reg; // R10
            temp_monitor_pkg::RD_REMOTE_LOW: read_mux = remote_low_reg; // R10
            temp_monitor_pkg::RD_MAKER_ID: read_mux = MAKER_ID_VALUE;
            temp_monitor_pkg::RD_REVISION: read_mux = REVISION_VALUE;
            default: read_mux = temp_monitor_pkg::INVALID_READ;
        endcase
    end

    always_comb begin
        case (state_reg)
            IDLE: state_next = start_w ? CONVERT : IDLE; // R13 R21
            CONVERT: state_next = conv_done ? IDLE : CONVERT;
            default: state_next = IDLE;
        endcase
    end

    // Standby pin synchroniser
    always_ff @(posedge clock) begin
        if (rst) begin
            standby_meta_reg <= 1'b1;
            standby_sync_reg <= 1'b1;
        end else begin
            standby_meta_reg <= standby_pin_n;
            standby_sync_reg <= standby_meta_reg;
        end
    end

    // Pointer and writable registers
    always_ff @(posedge clock) begin
        if (rst) begin
            pointer_reg <= temp_monitor_pkg::POINTER_RESET;
            alert_suppress_reg <=
                temp_monitor_pkg::CONFIG_RESET[temp_monitor_pkg::CONFIG_SUPPRESS_BIT];
            standby_cfg_reg <=
                temp_monitor_pkg::CONFIG_RESET[temp_monitor_pkg::CONFIG_STANDBY_BIT];
            rate_reg <= temp_monitor_pkg::RATE_RESET;
            local_high_reg <= temp_monitor_pkg::HIGH_LIMIT_RESET; // R11
            local_low_reg <= temp_monitor_pkg::LOW_LIMIT_RESET; // R11
            remote_high_reg <= temp_monitor_pkg::HIGH_LIMIT_RESET; // R11
            remote_low_reg <= temp_monitor_pkg::LOW_LIMIT_RESET; // R11
        end else begin
            if (wr_pointer) begin
                pointer_reg <= wr_data; // R22
            end
            if (wr_config) begin
                alert_suppress_reg <= wr_data[temp_monitor_pkg::CONFIG_SUPPRESS_BIT]; // R16
                standby_cfg_reg <= wr_data[temp_monitor_pkg::CONFIG_STANDBY_BIT]; // R13
            end
            if (wr_rate) begin
                rate_reg <= wr_data;
            end
            if (wr_local_high) begin
                local_high_reg <= wr_data; // R10
            end
            if (wr_local_low) begin
                local_low_reg <= wr_data; // R10
            end
            if (wr_remote_high) begin
                remote_high_reg <= wr_data; // R10
            end
            if (wr_remote_low) begin
                remote_low_reg <= wr_data; // R10
            end
        end
    end

    // Value registers follow the converter only
    always_ff @(posedge clock) begin
        if (rst) begin
            local_value_reg <= temp_monitor_pkg::VALUE_RESET; // R11
            remote_value_reg <= temp_monitor_pkg::VALUE_RESET; // R11
        end else if (result_take) begin
            local_value_reg <= local_result; // R1 R15
            remote_value_reg <= remote_result; // R1 R15
        end
    end

    // Flags and alert latch
    always_ff @(posedge clock) begin
        if (rst) begin
            local_over_flag_reg <= 1'b0;
            local_under_flag_reg <= 1'b0;
            remote_over_flag_reg <= 1'b0;
            remote_under_flag_reg <= 1'b0;
            open_flag_reg <= 1'b0;
            alert_latch_reg <= 1'b0;
        end else begin
            local_over_flag_reg <= local_over_next;
            local_under_flag_reg <= local_under_next;
            remote_over_flag_reg <= remote_over_next;
            remote_under_flag_reg <= remote_under_next;
            open_flag_reg <= open_next;
            alert_latch_reg <= alert_latch_next;
        end
    end

    // Conversion scheduling; the one-shot data byte is not kept
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= IDLE;
            oneshot_pending_reg <= 1'b0;
            period_count_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            if (wr_oneshot) begin
                oneshot_pending_reg <= 1'b1; // R12
            end else if (start_w) begin
                oneshot_pending_reg <= 1'b0; // R21
            end
            if (start_w || standby) begin
                period_count_reg <= 32'h0;
            end else if (!period_hit) begin
                period_count_reg <= period_count_reg + 32'h1; // R17
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_data_reg <= temp_monitor_pkg::INVALID_READ;
            conv_start_reg <= 1'b0;
            busy_reg <= 1'b0;
            alert_n_reg <= 1'b1;
            alert_oe_reg <= 1'b0;
        end else begin
            rd_data_reg <= read_mux;
            conv_start_reg <= start_w; // R12
            busy_reg <= (state_next == CONVERT); // R2 R24
            alert_n_reg <= !alert_latch_next; // R6
            alert_oe_reg <= alert_latch_next; // R6
        end
    end

    assign rd_data = rd_data_reg;
    assign conv_start = conv_start_reg;
    assign busy = busy_reg;
    assign alert_n = alert_n_reg;
    assign alert_oe = alert_oe_reg;

    // Checks
    a_value_readonly: assert property (@(posedge clock) disable iff (rst) // R1
        !$past(result_take) |-> $stable(local_value_reg) && $stable(remote_value_reg))
        else $error("value register changed without converter result");
    a_busy_live: assert property (@(posedge clock) disable iff (rst) // R2
        busy_reg == (state_reg == CONVERT))
        else $error("busy bit does not follow conversion state");
    a_flag_cause: assert property (@(posedge clock) disable iff (rst) // R7
        local_over_cond |=> local_over_flag_reg && status_byte[6])
        else $error("local over flag missing while out of limit");
    a_flag_sticky: assert property (@(posedge clock) disable iff (rst) // R8
        remote_under_flag_reg && !status_read |=> remote_under_flag_reg)
        else $error("remote under flag dropped without status read");
    a_alert_masked: assert property (@(posedge clock) disable iff (rst) // R6
        $rose(alert_latch_reg) |-> $past(!alert_suppress_reg && any_flag))
        else $error("alert latch set while masked or no flag");
    a_alert_status_read: assert property (@(posedge clock) disable iff (rst) // R9
        alert_latch_reg && status_read && !alert_resp_read |=> alert_latch_reg)
        else $error("status read cleared alert latch");
    a_alert_pin: assert property (@(posedge clock) disable iff (rst) // R6
        alert_latch_reg |-> !alert_n_reg && alert_oe_reg)
        else $error("alert pin not low while latch set");
    a_oneshot_start: assert property (@(posedge clock) disable iff (rst) // R12
        wr_oneshot && state_reg == IDLE |-> ##[1:2] conv_start_reg)
        else $error("one-shot write did not start a conversion");
    a_standby_quiet: assert property (@(posedge clock) disable iff (rst) // R13
        standby && !oneshot_pending_reg |=> !conv_start_reg)
        else $error("conversion started in standby");
    a_reset_values: assert property (@(posedge clock) // R11
        rst |=> local_value_reg == 8'h80 && local_high_reg == 8'h7f
            && remote_low_reg == 8'hc9)
        else $error("wrong reset value");
    a_reserved_zero: assert property (@(posedge clock) disable iff (rst) // R23
        status_byte[1:0] == 2'h0 && config_byte[5:0] == 6'h0)
        else $error("reserved bits not zero");

    c_oneshot: cover property (@(posedge clock) disable iff (rst)
        standby && wr_oneshot ##[1:4] conv_start_reg);
    c_status_clear: cover property (@(posedge clock) disable iff (rst)
        local_over_flag_reg && status_read && !local_over_cond ##1 !local_over_flag_reg);
    c_alert_clear: cover property (@(posedge clock) disable iff (rst)
        alert_latch_reg && alert_clear ##1 !alert_latch_reg);
    c_result: cover property (@(posedge clock) disable iff (rst) result_take);

endmodule : temp_monitor_register_bank

// >>> bus_host_model.sv
// Host model driving the byte strobes of the register bank
`timescale 1ns/1ps
module bus_host_model (
    input wire logic clock,        // Bank clock
    output logic wr_valid,         // Write byte strobe
    output logic wr_first,         // First byte of a write
    output logic [7:0] wr_data,    // Write byte
    output logic rd_req,           // Read byte consumed
    output logic alert_resp_read   // Alert-response read
);
    initial begin
        wr_valid = 1'b0;
        wr_first = 1'b0;
        wr_data = 8'h00;
        rd_req = 1'b0;
        alert_resp_read = 1'b0;
    end

    // Pointer byte, then an optional data byte; data line toggles once released
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, input bit with_data);
        @(negedge clock);
        wr_valid <= 1'b1;
        wr_first <= 1'b1;
        wr_data <= ptr;
        if (with_data) begin
            @(negedge clock);
            wr_first <= 1'b0;
            wr_data <= data;
        end
        @(negedge clock);
        wr_valid <= 1'b0;
        wr_first <= 1'b0;
        wr_data <= ~wr_data;
    endtask : write_reg

    task automatic read_byte(input logic [7:0] ptr);
        write_reg(ptr, 8'h00, 1'b0);
        @(negedge clock);
        rd_req <= 1'b1;
        @(negedge clock);
        rd_req <= 1'b0;
    endtask : read_byte

    task automatic alert_response();
        @(negedge clock);
        alert_resp_read <= 1'b1;
        @(negedge clock);
        alert_resp_read <= 1'b0;
    endtask : alert_response
endmodule : bus_host_model

// >>> tb.sv
// Self-checking testbench of the temperature monitor register bank
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] MAKER_ID = 8'h6b; // Arbitrary value
    localparam logic [7:0] REVISION = 8'h07; // Arbitrary value
    localparam logic [7:0] RST_ADDR [10] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h08, 8'hfe, 8'hff};
    localparam logic [7:0] RST_VAL [10] = '{8'h80, 8'h80, 8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f,
        8'hc9, MAKER_ID, REVISION};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic standby_pin_n = 1'b0;
    logic conv_done = 1'b0;
    logic [7:0] local_result = 8'h00;
    logic [7:0] remote_result = 8'h00;
    logic sensor_open = 1'b0;
    logic wr_valid, wr_first, rd_req, alert_resp_read, conv_start, busy, alert_n, alert_oe;
    logic [7:0] wr_data, rd_data, lim;
    logic [7:0] exp_q [$];
    int errors = 0;
    int samples_checked = 0;
    int conv_delay = 20;
    int n, g7, g5;

    always #2.5 clock = ~clock;

    bus_host_model host (.clock(clock), .wr_valid(wr_valid), .wr_first(wr_first),
        .wr_data(wr_data), .rd_req(rd_req), .alert_resp_read(alert_resp_read));

    temp_monitor_register_bank #(.BASE_PERIOD_CYCLES(32'h14), .MAKER_ID_VALUE(MAKER_ID),
        .REVISION_VALUE(REVISION)) dut (.clock(clock), .rst(rst), .wr_valid(wr_valid),
        .wr_first(wr_first), .wr_data(wr_data), .rd_req(rd_req),
        .alert_resp_read(alert_resp_read), .standby_pin_n(standby_pin_n),
        .conv_done(conv_done), .local_result(local_result), .remote_result(remote_result),
        .sensor_open(sensor_open), .rd_data(rd_data), .conv_start(conv_start), .busy(busy),
        .alert_n(alert_n), .alert_oe(alert_oe));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
        exp_q.push_back(exp);
        host.read_byte(ptr);
    endtask : rd

    task automatic wait_conv(input int bound, output int cnt);
        cnt = 0;
        while (conv_start !== 1'b1) begin
            @(negedge clock);
            cnt++;
            if (cnt > bound) begin
                errors++;
                report_and_stop();
            end
        end
    endtask : wait_conv

    task automatic count_starts(input int cycles, output int cnt);
        cnt = 0;
        repeat (cycles) begin
            @(negedge clock);
            if (conv_start === 1'b1) cnt++;
        end
    endtask : count_starts

    // Read results are compared with the oldest note when the host consumes a byte
    always @(posedge clock) begin
        if (rd_req === 1'b1) check(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data);
    end

    // Converter model answering each start after conv_delay cycles
    always @(posedge clock) begin
        if (conv_start === 1'b1) begin
            repeat (conv_delay) @(negedge clock);
            conv_done <= 1'b1;
            @(negedge clock);
            conv_done <= 1'b0;
        end
    end

    initial begin
        void'($urandom(32'h747c78eb));
        repeat (8) @(negedge clock);
        rst <= 1'b0;
        foreach (RST_ADDR[i]) rd(RST_ADDR[i], RST_VAL[i]);
        rd(temp_monitor_pkg::RD_STATUS, 8'h28);
        check({alert_oe, alert_n}, 8'h02);
        host.write_reg(temp_monitor_pkg::RD_LOCAL_HIGH, 8'h11, 1'b1);
        rd(temp_monitor_pkg::RD_LOCAL_HIGH, 8'h7f);
        rd(temp_monitor_pkg::WR_LOCAL_HIGH, 8'h00);
        for (int i = 0; i < 4; i++) begin
            lim = 8'($urandom);
            host.write_reg(temp_monitor_pkg::WR_LOCAL_HIGH + 8'(i), lim, 1'b1);
            rd(temp_monitor_pkg::RD_LOCAL_HIGH + 8'(i), lim);
        end
        host.write_reg(temp_monitor_pkg::WR_LOCAL_HIGH, 8'h40, 1'b1);
        host.write_reg(temp_monitor_pkg::WR_LOCAL_LOW, 8'h80, 1'b1);
        host.write_reg(temp_monitor_pkg::WR_REMOTE_HIGH, 8'h7f, 1'b1);
        host.write_reg(temp_monitor_pkg::WR_REMOTE_LOW, 8'h80, 1'b1);
        rd(temp_monitor_pkg::RD_STATUS, 8'h28);
        rd(temp_monitor_pkg::RD_STATUS, 8'h00);
        check({7'h00, alert_n}, 8'h00);
        host.alert_response();
        @(negedge clock);
        check({7'h00, alert_n}, 8'h01);
        local_result = 8'h50;
        remote_result = 8'h7f;
        host.write_reg(temp_monitor_pkg::WR_ONE_SHOT, 8'($urandom), 1'b1);
        wait_conv(10, n);
        check({7'h00, busy}, 8'h01);
        repeat (conv_delay + 3) @(negedge clock);
        check({7'h00, busy}, 8'h00);
        count_starts(100, n);
        check(8'(n), 8'h00);
        rd(temp_monitor_pkg::RD_LOCAL_VALUE, 8'h50);
        rd(temp_monitor_pkg::RD_REMOTE_VALUE, 8'h7f);
        rd(temp_monitor_pkg::RD_STATUS, 8'h40);
        check({7'h00, alert_n}, 8'h00);
        host.write_reg(temp_monitor_pkg::WR_CONFIG, 8'hff, 1'b1);
        rd(temp_monitor_pkg::RD_CONFIG, 8'hc0);
        host.write_reg(temp_monitor_pkg::WR_LOCAL_HIGH, 8'h7f, 1'b1);
        rd(temp_monitor_pkg::RD_STATUS, 8'h40);
        host.alert_response();
        sensor_open = 1'b1;
        rd(temp_monitor_pkg::RD_STATUS, 8'h04);
        rd(temp_monitor_pkg::RD_STATUS, 8'h04);
        check({7'h00, alert_n}, 8'h01);
        sensor_open = 1'b0;
        rd(temp_monitor_pkg::RD_STATUS, 8'h04);
        rd(temp_monitor_pkg::RD_STATUS, 8'h00);
        conv_delay = 2;
        local_result = 8'h10;
        host.write_reg(temp_monitor_pkg::WR_CONFIG, 8'h00, 1'b1);
        host.write_reg(temp_monitor_pkg::WR_RATE, 8'h07, 1'b1);
        rd(temp_monitor_pkg::RD_RATE, 8'h07);
        standby_pin_n = 1'b1;
        wait_conv(3000, n);
        @(negedge clock);
        wait_conv(3000, g7);
        host.write_reg(temp_monitor_pkg::WR_RATE, 8'h05, 1'b1);
        wait_conv(3000, n);
        @(negedge clock);
        wait_conv(3000, g5);
        check(8'(g5 > 2 * g7), 8'h01);
        host.write_reg(temp_monitor_pkg::WR_CONFIG, 8'h40, 1'b1);
        repeat (10) @(negedge clock);
        local_result = 8'h33;
        count_starts(300, n);
        check(8'(n), 8'h00);
        rd(temp_monitor_pkg::RD_LOCAL_VALUE, 8'h10);
        host.write_reg(temp_monitor_pkg::WR_CONFIG, 8'h00, 1'b1);
        standby_pin_n = 1'b0;
        count_starts(300, n);
        check(8'(n), 8'h00);
        report_and_stop();
    end
endmodule : tb
